// file: shared/dag_pkg.sv
/*
 package of the descriptor address generator: address width, header
 field layout, addressing modes, data type codes and their lengths.
 assumes little-endian multi-byte fields in descriptor memory.
*/
package dag_pkg;
   localparam int ADDR_W = 24;
   localparam logic [23:0] ADDR_ZERO = 24'h000000;
   localparam logic [23:0] ADDR_ONE = 24'h000001;
   localparam logic [23:0] BASE_ENTRY_BYTES = 24'h000003;
   // header byte: check, flag, type[5:2], mode[1:0]
   localparam int HDR_CHK_BIT = 7;
   localparam int HDR_FLAG_BIT = 6;
   localparam int HDR_TYPE_HI = 5;
   localparam int HDR_TYPE_LO = 2;
   localparam int HDR_MODE_HI = 1;
   localparam int HDR_MODE_LO = 0;
   localparam logic [1:0] MODE_ATTACHED = 2'h0;
   localparam logic [1:0] MODE_SHORT = 2'h1;
   localparam logic [1:0] MODE_LONG = 2'h2;
   localparam logic [1:0] MODE_LOGICAL = 2'h3;
   localparam logic [1:0] LEN_ATTACHED = 2'h0;
   localparam logic [1:0] LEN_SHORT = 2'h1;
   localparam logic [1:0] LEN_LONG = 2'h2;
   localparam logic [1:0] LEN_LOGICAL = 2'h3;
   localparam logic [1:0] LEN_STRING = 2'h2;
   localparam logic [3:0] TYPE_ORDINAL = 4'h2;
   localparam logic [3:0] TYPE_INT4 = 4'h4;
   localparam logic [3:0] TYPE_REAL4 = 4'h6;
   localparam logic [3:0] TYPE_BCD4 = 4'h9;
   localparam logic [3:0] TYPE_STRING = 4'hb;
   localparam logic [3:0] TYPE_RECORD = 4'hc;
   localparam logic [3:0] TYPE_ARRAY = 4'hd;
   localparam logic [7:0] DLEN_ORDINAL = 8'h03;
   localparam logic [7:0] DLEN_FOUR = 8'h04;
   localparam logic [7:0] DLEN_DEFAULT = 8'h01;
   localparam logic [1:0] CNT_ZERO = 2'h0;
   localparam logic [1:0] CNT_ONE = 2'h1;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [15:0] HALF_ZERO = 16'h0000;
endpackage

// file: src/dag_mac.sv
/*
 multiply-accumulate step: result = acc + length * index, registered.
 assumes start is a one-cycle pulse; done follows one edge later.
*/
`timescale 1ns/1ps
module dag_mac
   import dag_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic start,
   input wire logic [23:0] acc,
   input wire logic [7:0] len,
   input wire logic [7:0] idx,
   output logic [23:0] result,
   output logic done
);
   logic [23:0] result_reg;
   logic [23:0] result_next;
   logic done_reg;
   logic done_next;

   always_comb begin
      result_next = result_reg;
      done_next = start;
      if (start) begin
         // widen before multiplying: a byte-wide product would drop the upper half
         result_next = acc + {8'h00, 16'(len) * 16'(idx)};
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         result_reg <= ADDR_ZERO;
         done_reg <= 1'b0;
      end else begin
         result_reg <= result_next;
         done_reg <= done_next;
      end
   end

   assign result = result_reg;
   assign done = done_reg;

   chk_mac_sum_value: assert property (@(posedge clk) disable iff (rst)
      start |=> done && result == $past(acc) + {8'h00, 16'($past(len)) * 16'($past(idx))})
      else $error("accumulated element offset is wrong");
endmodule

// file: src/dag_top.sv
/*
 descriptor address generator: walks array and record descriptors in
 memory, consuming index and field selection bytes from the instruction
 stream, and delivers the 24-bit logical operand address.
 assumes a byte instruction port and a byte memory read port, each with
 a level request answered by a one-cycle acknowledge.
*/
// Notes on behaviour
// - array descriptor address is primary pointer plus next instruction byte
// - following instruction bytes are indices for dimensions one, two, three
// - address sums base info plus length times index per level plus offsets
// - no trap on an index whose level does not request range checking
// - checked level traps when its index exceeds the stored maximum index
// - relative offset counts from the byte after the addressing information
// - external base: instruction ordinal selects base page entry holding descriptor address
// - record descriptor is header, addressing information, then field descriptors
// - logical record: three bytes after header give raw data start
// - next instruction byte plus field area start locates the field descriptor
// - short relocatable field offset byte is added to the raw data start
// - string field: two bytes after the offset give the string length
// - nested record field takes another instruction byte as field displacement
`timescale 1ns/1ps
module dag_top
   import dag_pkg::*;
(
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic START,
   input wire logic EXT_BASE,
   input wire logic [23:0] PRIMARY_POINTER_REGISTER,
   input wire logic [23:0] BASE_PAGE_REGISTER,
   output logic INS_REQ,
   input wire logic INS_ACK,
   input wire logic [7:0] INS_BYTE,
   output logic MEM_REQ,
   output logic [23:0] MEM_ADDR,
   input wire logic MEM_ACK,
   input wire logic [7:0] MEM_RDATA,
   output logic BUSY,
   output logic [23:0] OPERAND_ADDR,
   output logic ADDR_VALID,
   output logic RANGE_TRAP,
   output logic [15:0] STRING_LEN
);
   typedef enum logic [3:0] {
      S_IDLE, S_GET_DISP, S_GET_ORD, S_RD_ENTRY, S_RD_HDR, S_RD_ADDR,
      S_RD_LEN, S_RD_MAX, S_GET_IDX, S_MAC, S_GET_SEL, S_RD_SLEN
   } dag_state_t;

   dag_state_t state_reg, state_next;
   logic [23:0] ptr_reg, ptr_next;
   logic [23:0] acc_reg, acc_next;
   logic [23:0] raw_reg, raw_next;
   logic [23:0] area_reg, area_next;
   logic [23:0] asm_reg, asm_next;
   logic [1:0] cnt_reg, cnt_next;
   logic [7:0] hdr_reg, hdr_next;
   logic [7:0] len_reg, len_next;
   logic [7:0] max_reg, max_next;
   logic [7:0] idx_reg, idx_next;
   logic top_reg, top_next;
   logic [23:0] out_reg, out_next;
   logic valid_reg, valid_next;
   logic trap_reg, trap_next;
   logic [15:0] slen_reg, slen_next;
   logic mac_start;
   logic mac_done;
   logic [23:0] mac_result;
   logic [23:0] asm_in;
   logic [1:0] nbytes;
   logic [23:0] ptr_after;
   logic [23:0] addr_val;
   logic [3:0] htype;

   function automatic logic [1:0] addr_bytes(input logic [1:0] mode);
      case (mode)
         MODE_LOGICAL: addr_bytes = LEN_LOGICAL;
         MODE_LONG: addr_bytes = LEN_LONG;
         MODE_SHORT: addr_bytes = LEN_SHORT;
         default: addr_bytes = LEN_ATTACHED;
      endcase
   endfunction

   function automatic logic [7:0] type_len(input logic [3:0] t);
      case (t)
         TYPE_ORDINAL: type_len = DLEN_ORDINAL;
         TYPE_INT4, TYPE_REAL4, TYPE_BCD4: type_len = DLEN_FOUR;
         default: type_len = DLEN_DEFAULT;
      endcase
   endfunction

   // little-endian byte placement; first byte clears older content
   function automatic logic [23:0] put_byte(input logic [23:0] a, input logic [1:0] c,
                                            input logic [7:0] b);
      logic [23:0] r;
      r = (c == CNT_ZERO) ? ADDR_ZERO : a;
      r[c*8 +: 8] = b;
      put_byte = r;
   endfunction

   dag_mac u_mac (
      .clk(CLOCK),
      .rst(RST),
      .start(mac_start),
      .acc(acc_reg),
      .len(len_reg),
      .idx(INS_BYTE),
      .result(mac_result),
      .done(mac_done)
   );

   always_comb begin
      htype = hdr_reg[HDR_TYPE_HI:HDR_TYPE_LO];
      nbytes = addr_bytes(hdr_reg[HDR_MODE_HI:HDR_MODE_LO]);
      asm_in = put_byte(asm_reg, cnt_reg, MEM_RDATA);
      ptr_after = MEM_ACK ? ptr_reg + ADDR_ONE : ptr_reg;
      addr_val = (nbytes == LEN_ATTACHED) ? ADDR_ZERO : asm_in;
      state_next = state_reg;
      ptr_next = ptr_reg;
      acc_next = acc_reg;
      raw_next = raw_reg;
      area_next = area_reg;
      asm_next = asm_reg;
      cnt_next = cnt_reg;
      hdr_next = hdr_reg;
      len_next = len_reg;
      max_next = max_reg;
      idx_next = idx_reg;
      top_next = top_reg;
      out_next = out_reg;
      valid_next = 1'b0;
      trap_next = 1'b0;
      slen_next = slen_reg;
      mac_start = 1'b0;
      if (MEM_REQ && MEM_ACK) begin
         asm_next = asm_in;
         ptr_next = ptr_reg + ADDR_ONE;
         cnt_next = cnt_reg + CNT_ONE;
      end
      case (state_reg)
         S_IDLE: begin
            if (START) begin
               top_next = 1'b1;
               acc_next = ADDR_ZERO;
               slen_next = HALF_ZERO;
               state_next = EXT_BASE ? S_GET_ORD : S_GET_DISP;
            end
         end
         S_GET_DISP: begin
            if (INS_ACK) begin
               ptr_next = PRIMARY_POINTER_REGISTER + {16'h0000, INS_BYTE};
               state_next = S_RD_HDR;
            end
         end
         S_GET_ORD: begin
            if (INS_ACK) begin
               ptr_next = BASE_PAGE_REGISTER + 24'({16'h0000, INS_BYTE} * BASE_ENTRY_BYTES);
               cnt_next = CNT_ZERO;
               state_next = S_RD_ENTRY;
            end
         end
         S_RD_ENTRY: begin
            if (MEM_ACK && cnt_reg == LEN_LOGICAL - CNT_ONE) begin
               ptr_next = asm_in;
               cnt_next = CNT_ZERO;
               state_next = S_RD_HDR;
            end
         end
         S_RD_HDR: begin
            if (MEM_ACK) begin
               hdr_next = MEM_RDATA;
               cnt_next = CNT_ZERO;
               state_next = S_RD_ADDR;
            end
         end
         S_RD_ADDR: begin
            if (nbytes == LEN_ATTACHED || (MEM_ACK && cnt_reg == nbytes - CNT_ONE)) begin
               cnt_next = CNT_ZERO;
               top_next = 1'b0;
               if (hdr_reg[HDR_MODE_HI:HDR_MODE_LO] == MODE_LOGICAL) begin
                  acc_next = addr_val;
               end else if (top_reg) begin
                  acc_next = ptr_after + addr_val;
               end else begin
                  acc_next = acc_reg + addr_val;
               end
               if (hdr_reg[HDR_FLAG_BIT]) begin
                  len_next = type_len(htype);
                  state_next = hdr_reg[HDR_CHK_BIT] ? S_RD_MAX : S_GET_IDX;
               end else if (htype == TYPE_ARRAY) begin
                  state_next = S_RD_LEN;
               end else if (htype == TYPE_RECORD) begin
                  area_next = ptr_after;
                  state_next = S_GET_SEL;
               end else if (htype == TYPE_STRING) begin
                  state_next = S_RD_SLEN;
               end else begin
                  state_next = S_IDLE;
               end
               if (state_next == S_IDLE) begin
                  valid_next = 1'b1;
               end
               if (htype == TYPE_RECORD) begin
                  raw_next = acc_next;
               end
               out_next = acc_next;
            end
         end
         S_RD_LEN: begin
            if (MEM_ACK) begin
               len_next = MEM_RDATA;
               state_next = hdr_reg[HDR_CHK_BIT] ? S_RD_MAX : S_GET_IDX;
            end
         end
         S_RD_MAX: begin
            if (MEM_ACK) begin
               max_next = MEM_RDATA;
               state_next = S_GET_IDX;
            end
         end
         S_GET_IDX: begin
            if (INS_ACK) begin
               idx_next = INS_BYTE;
               if (hdr_reg[HDR_CHK_BIT] && INS_BYTE > max_reg) begin
                  trap_next = 1'b1;
                  state_next = S_IDLE;
               end else begin
                  mac_start = 1'b1;
                  state_next = S_MAC;
               end
            end
         end
         S_MAC: begin
            if (mac_done) begin
               acc_next = mac_result;
               if (hdr_reg[HDR_FLAG_BIT]) begin
                  out_next = mac_result;
                  valid_next = 1'b1;
                  state_next = S_IDLE;
               end else begin
                  state_next = S_RD_HDR;
               end
            end
         end
         S_GET_SEL: begin
            if (INS_ACK) begin
               ptr_next = area_reg + {16'h0000, INS_BYTE};
               acc_next = raw_reg;
               state_next = S_RD_HDR;
            end
         end
         S_RD_SLEN: begin
            if (MEM_ACK && cnt_reg == LEN_STRING - CNT_ONE) begin
               slen_next = asm_in[15:0];
               valid_next = 1'b1;
               state_next = S_IDLE;
            end
         end
         default: state_next = S_IDLE;
      endcase
   end

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         state_reg <= S_IDLE;
         ptr_reg <= ADDR_ZERO;
         acc_reg <= ADDR_ZERO;
         raw_reg <= ADDR_ZERO;
         area_reg <= ADDR_ZERO;
         asm_reg <= ADDR_ZERO;
         cnt_reg <= CNT_ZERO;
         hdr_reg <= BYTE_ZERO;
         len_reg <= BYTE_ZERO;
         max_reg <= BYTE_ZERO;
         idx_reg <= BYTE_ZERO;
         top_reg <= 1'b0;
         out_reg <= ADDR_ZERO;
         valid_reg <= 1'b0;
         trap_reg <= 1'b0;
         slen_reg <= HALF_ZERO;
      end else begin
         state_reg <= state_next;
         ptr_reg <= ptr_next;
         acc_reg <= acc_next;
         raw_reg <= raw_next;
         area_reg <= area_next;
         asm_reg <= asm_next;
         cnt_reg <= cnt_next;
         hdr_reg <= hdr_next;
         len_reg <= len_next;
         max_reg <= max_next;
         idx_reg <= idx_next;
         top_reg <= top_next;
         out_reg <= out_next;
         valid_reg <= valid_next;
         trap_reg <= trap_next;
         slen_reg <= slen_next;
      end
   end

   assign INS_REQ = state_reg == S_GET_DISP || state_reg == S_GET_ORD ||
                    state_reg == S_GET_IDX || state_reg == S_GET_SEL;
   assign MEM_REQ = state_reg == S_RD_ENTRY || state_reg == S_RD_HDR ||
                    state_reg == S_RD_LEN || state_reg == S_RD_MAX || state_reg == S_RD_SLEN ||
                    (state_reg == S_RD_ADDR && nbytes != LEN_ATTACHED);
   assign MEM_ADDR = ptr_reg;
   assign BUSY = state_reg != S_IDLE;
   assign OPERAND_ADDR = out_reg;
   assign ADDR_VALID = valid_reg;
   assign RANGE_TRAP = trap_reg;
   assign STRING_LEN = slen_reg;

   chk_desc_addr_sum: assert property (@(posedge CLOCK) disable iff (RST)
      state_reg == S_GET_DISP && INS_ACK
      |=> ptr_reg == $past(PRIMARY_POINTER_REGISTER) + {16'h0000, $past(INS_BYTE)})
      else $error("descriptor address is not pointer plus displacement");
   chk_index_to_mac: assert property (@(posedge CLOCK) disable iff (RST)
      state_reg == S_GET_IDX && INS_ACK && !RANGE_TRAP ##1 !trap_reg
      |-> idx_reg == $past(INS_BYTE) && mac_done)
      else $error("index byte not carried into the sum");
   chk_no_trap_unchecked: assert property (@(posedge CLOCK) disable iff (RST)
      state_reg == S_GET_IDX && INS_ACK && !hdr_reg[HDR_CHK_BIT] |=> !RANGE_TRAP)
      else $error("trap raised on an unchecked index");
   chk_trap_over_max: assert property (@(posedge CLOCK) disable iff (RST)
      state_reg == S_GET_IDX && INS_ACK && hdr_reg[HDR_CHK_BIT] && INS_BYTE > max_reg
      |=> RANGE_TRAP && state_reg == S_IDLE)
      else $error("index above maximum did not trap");
   chk_base_entry: assert property (@(posedge CLOCK) disable iff (RST)
      state_reg == S_GET_ORD && INS_ACK |=> state_reg == S_RD_ENTRY &&
      ptr_reg == $past(BASE_PAGE_REGISTER) + 24'({16'h0000, $past(INS_BYTE)} * BASE_ENTRY_BYTES))
      else $error("base page entry address wrong");
   chk_field_select: assert property (@(posedge CLOCK) disable iff (RST)
      state_reg == S_GET_SEL && INS_ACK
      |=> ptr_reg == $past(area_reg) + {16'h0000, $past(INS_BYTE)} && acc_reg == raw_reg)
      else $error("field descriptor address wrong");
   chk_string_length: assert property (@(posedge CLOCK) disable iff (RST)
      state_reg == S_RD_SLEN && MEM_ACK && cnt_reg == CNT_ONE
      |=> ADDR_VALID && STRING_LEN[15:8] == $past(MEM_RDATA))
      else $error("string length not taken from field descriptor");
   chk_valid_pulse: assert property (@(posedge CLOCK) disable iff (RST)
      ADDR_VALID |-> state_reg == S_IDLE ##1 !ADDR_VALID)
      else $error("operand address strobe longer than one cycle");
endmodule

// file: tb/dag_mem_model.sv
/*
 memory and instruction stream model facing the address generator.
 assumes the bench loads bytes and the latency while the block is idle.
*/
`timescale 1ns/1ps
module dag_mem_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic ins_req,
   output logic ins_ack,
   output logic [7:0] ins_byte,
   input wire logic mem_req,
   input wire logic [23:0] mem_addr,
   output logic mem_ack,
   output logic [7:0] mem_rdata
);
   logic [7:0] mem [logic [23:0]];
   logic [7:0] ins_q [$];
   int lat = 0;
   int mcnt = 0;
   int icnt = 0;
   logic [7:0] junk = 8'h5a;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         ins_ack <= 1'b0;
         mem_ack <= 1'b0;
         ins_byte <= 8'h00;
         mem_rdata <= 8'h00;
      end else begin
         // data lines wander whenever nothing is acknowledged
         junk <= junk + 8'h35;
         ins_ack <= 1'b0;
         mem_ack <= 1'b0;
         ins_byte <= junk;
         mem_rdata <= ~junk;
         if (mem_req && !mem_ack) begin
            if (mcnt >= lat) begin
               mem_ack <= 1'b1;
               mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : ~mem_addr[7:0];
               mcnt <= 0;
            end else begin
               mcnt <= mcnt + 1;
            end
         end
         if (ins_req && !ins_ack && ins_q.size() > 0) begin
            if (icnt >= lat) begin
               ins_ack <= 1'b1;
               ins_byte <= ins_q.pop_front();
               icnt <= 0;
            end else begin
               icnt <= icnt + 1;
            end
         end
      end
   end
endmodule

// file: tb/testbench.sv
/*
 self-checking bench of the descriptor address generator.
 assumes dag_top and the memory model; descriptors use the design's
 header layout: check, flag, type, mode.
*/
`timescale 1ns/1ps
module testbench;
   logic CLOCK = 1'b0;
   logic RST = 1'b1;
   logic START = 1'b0;
   logic EXT_BASE = 1'b0;
   logic [23:0] PTR = 24'h000000;
   logic [23:0] BASE = 24'h000100;
   logic INS_REQ, INS_ACK, MEM_REQ, MEM_ACK, BUSY, ADDR_VALID, RANGE_TRAP;
   logic [7:0] INS_BYTE, MEM_RDATA;
   logic [23:0] MEM_ADDR, OPERAND_ADDR;
   logic [15:0] STRING_LEN;
   int miscompares = 0;
   int n_compared = 0;
   int cycles = 0;

   dag_top dag_top_inst (.CLOCK(CLOCK), .RST(RST), .START(START), .EXT_BASE(EXT_BASE),
      .PRIMARY_POINTER_REGISTER(PTR), .BASE_PAGE_REGISTER(BASE), .INS_REQ(INS_REQ),
      .INS_ACK(INS_ACK), .INS_BYTE(INS_BYTE), .MEM_REQ(MEM_REQ), .MEM_ADDR(MEM_ADDR),
      .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA), .BUSY(BUSY), .OPERAND_ADDR(OPERAND_ADDR),
      .ADDR_VALID(ADDR_VALID), .RANGE_TRAP(RANGE_TRAP), .STRING_LEN(STRING_LEN));

   dag_mem_model dag_mem_model_inst (.clk(CLOCK), .rst(RST), .ins_req(INS_REQ),
      .ins_ack(INS_ACK), .ins_byte(INS_BYTE), .mem_req(MEM_REQ), .mem_addr(MEM_ADDR),
      .mem_ack(MEM_ACK), .mem_rdata(MEM_RDATA));

   initial begin
      forever #25 CLOCK = ~CLOCK;
   end

   task automatic tally_and_finish;
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   always @(posedge CLOCK) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         tally_and_finish;
      end
   end

   task automatic cmp_addr(input string what, input logic [23:0] exp, input logic [23:0] got);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic cmp_flag(input string what, input logic exp, input logic got);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic load(input logic [23:0] a, input logic [7:0] b[$]);
      foreach (b[i]) dag_mem_model_inst.mem[a + 24'(i)] = b[i];
   endtask

   // one walk: start, wait bounded for its end, judge trap, valid, operand address, string length, unused bytes and busy
   task automatic walk(input string name, input logic ext, input logic [23:0] ptr,
                       input int lat, input logic [7:0] ins[$], input logic [23:0] exp,
                       input logic trap, input logic [15:0] len);
      int n;
      n = 0;
      dag_mem_model_inst.lat = lat;
      dag_mem_model_inst.ins_q = ins;
      @(posedge CLOCK);
      EXT_BASE <= ext;
      PTR <= ptr;
      START <= 1'b1;
      @(posedge CLOCK);
      START <= 1'b0;
      do begin
         @(negedge CLOCK);
         n++;
      end while (ADDR_VALID !== 1'b1 && RANGE_TRAP !== 1'b1 && n < 500);
      cmp_flag("range trap", trap, RANGE_TRAP);
      cmp_flag("address valid", !trap, ADDR_VALID);
      if (!trap) begin
         cmp_addr("operand address", exp, OPERAND_ADDR);
      end
      cmp_addr("string length", {8'h00, len}, {8'h00, STRING_LEN});
      cmp_addr("unused bytes", 24'h000000, 24'(dag_mem_model_inst.ins_q.size()));
      @(negedge CLOCK);
      cmp_flag("busy after end", 1'b0, BUSY);
      $display("test %s done", name);
   endtask

   task automatic test_reset;
      @(negedge CLOCK);
      cmp_flag("busy in reset", 1'b0, BUSY);
      cmp_flag("ins request in reset", 1'b0, INS_REQ);
      cmp_flag("mem request in reset", 1'b0, MEM_REQ);
      cmp_addr("operand in reset", 24'h000000, OPERAND_ADDR);
      $display("test reset done");
   endtask

   task automatic test_array;
      walk("array", 1'b0, 24'h011fe0, 0, '{8'h10, 8'h0a, 8'h08, 8'h03},
           24'h123ebd, 1'b0, 16'h0000);
      walk("unchecked", 1'b0, 24'h011fe0, 2, '{8'h10, 8'h13, 8'h05, 8'hf8},
           24'h124ae6, 1'b0, 16'h0000);
   endtask

   task automatic test_range;
      walk("max index", 1'b0, 24'h011fe0, 1, '{8'h10, 8'h00, 8'h09, 8'h00},
           24'h123537, 1'b0, 16'h0000);
      walk("over max", 1'b0, 24'h011fe0, 0, '{8'h10, 8'h00, 8'h0a},
           24'h000000, 1'b1, 16'h0000);
   endtask

   task automatic test_ext_base;
      walk("external base", 1'b1, 24'h000000, 3, '{8'h20, 8'h08, 8'h02},
           24'h123ebd, 1'b0, 16'h0000);
   endtask

   task automatic test_records;
      walk("string field", 1'b1, 24'h000000, 0, '{8'h21, 8'h0c},
           24'h12347e, 1'b0, 16'h0104);
      walk("nested record", 1'b1, 24'h000000, 1, '{8'h21, 8'h07, 8'h00},
           24'h12347c, 1'b0, 16'h0000);
      walk("address wrap", 1'b0, 24'h0001f0, 0, '{8'h10, 8'h00},
           24'h000010, 1'b0, 16'h0000);
   endtask

   initial begin
      load(24'h011ff0, '{8'h37, 8'h56, 8'h34, 8'h12, 8'hf5, 8'hb5, 8'h05, 8'h18,
                         8'h09, 8'h59, 8'h04});
      load(24'h000160, '{8'he8, 8'h3d, 8'h12, 8'h34, 8'hf2, 8'h01});
      load(24'h123de8, '{8'h35, 8'h03, 8'h18, 8'h34, 8'h08, 8'h10});
      load(24'h01f234, '{8'h33, 8'h56, 8'h34, 8'h12});
      load(24'h01f23f, '{8'h31, 8'h26, 8'h04});
      load(24'h01f244, '{8'h2d, 8'h28, 8'h04, 8'h01});
      load(24'h000200, '{8'h33, 8'hf0, 8'hff, 8'hff, 8'h09, 8'h20});
      test_reset;
      repeat (5) @(posedge CLOCK);
      RST <= 1'b0;
      test_array;
      test_range;
      test_ext_base;
      test_records;
      tally_and_finish;
   end
endmodule
